//--- fsr_defines.vh
// Constants shared by the fault and reset supervisor
`ifndef FSR_DEFINES_VH
`define FSR_DEFINES_VH

// Cycle counts at 40 MHz, sized to the counters that load them
// Reset hold 2 ms, blanking 1 ms
`define FSR_RESET_HOLD_CYC 20'd80000
`define FSR_BLANK_CYC 20'd40000
// Wake 50 us, battery filter 20 us, overvoltage filter 10 us
`define FSR_WAKE_MIN_CYC 12'd2000
`define FSR_BATT_FILT_CYC 12'd800
`define FSR_OV_FILT_CYC 12'd400
// Soft-start step 10 us
`define FSR_RAMP_STEP_CYC 12'd400

`define FSR_ADDR_CTRL 8'h00
`define FSR_ADDR_CMD 8'h04
`define FSR_ADDR_STAT 8'h08

`define FSR_CTRL_OVSEL 0
`define FSR_CTRL_BATTSEL 1
`define FSR_CTRL_BOOSTEN 2
`define FSR_CTRL_LDOEN 3
`define FSR_CTRL_LIM_LO 8
`define FSR_CTRL_LIM_HI 11
`define FSR_CTRL_RESET 32'h0000_0404

`define FSR_CMD_SLEEP 0
`define FSR_CMD_LOCK 1

`define FSR_STAT_POR 0
`define FSR_STAT_WAKE 1
`define FSR_STAT_IRQ 2
`define FSR_STAT_PRI 3
`define FSR_STAT_PERI 4
`define FSR_STAT_ST_LO 8
`define FSR_STAT_ST_HI 16
`define FSR_STAT_TAL_LO 20
`define FSR_STAT_TAL_HI 23

`define FSR_RESP_OKAY 2'b00
`define FSR_RESP_SLVERR 2'b10

`endif

//--- fsr_filter.v
// Glitch filter: output rises after input is high for LEN cycles
`timescale 1ns/100ps
`default_nettype none
module fsr_filter #(
  parameter [11:0] LEN = 12'h001
) (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg [11:0] cnt_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 12'h000;
      dout <= 1'b0;
    end else if (!din) begin
      cnt_ff <= 12'h000;
      dout <= 1'b0;
    end else if (cnt_ff >= LEN - 12'h001) begin
      dout <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end
endmodule
`default_nettype wire

//--- fsr_supervisor.v
// Fault and reset supervisor with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defines.vh"
module fsr_supervisor #(
  parameter [19:0] RESET_HOLD_CYC = `FSR_RESET_HOLD_CYC,
  parameter [19:0] BLANK_CYC = `FSR_BLANK_CYC
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire VIN_POR_LOW,
  input wire LP_CLK_LOSS,
  input wire DIE_OVERTEMP,
  input wire CORE_SUPPLY_FAULT,
  input wire [2:0] BUCK_MON_FAULT,
  input wire LDO_OV,
  input wire IO_SUPPLY_UV,
  input wire GND_OPEN,
  input wire [2:0] BUCK_OVERTEMP,
  input wire GATE_SUPPLY_OVERTEMP,
  input wire GATE_SUPPLY_UV,
  input wire BUCK1_UV,
  input wire BOOST_OVERTEMP,
  input wire LDO_OVERTEMP,
  input wire WD_VIOLATION,
  input wire WD_TRIGGER,
  input wire WAKE,
  input wire BATT_BELOW_LOW_THR,
  input wire BATT_BELOW_HIGH_THR,
  input wire INPUT_OV_LOW_THR,
  input wire INPUT_OV_HIGH_THR,
  input wire INIT_DONE,
  input wire SELFTEST_BEGIN_OK,
  input wire SELFTEST_END_OK,
  input wire RAMP_DONE,
  output wire PASS_SWITCH_DRIVE,
  output wire BUCK1_RUN,
  output wire BOOST_EN,
  output wire LDO_EN,
  output wire [7:0] SOFTSTART_LEVEL,
  output wire LOWSIDE_DISCHARGE_EN,
  input wire PRI_RST_N_I,
  output wire PRI_RST_N_O,
  output wire PRI_RST_N_OE,
  input wire PERI_RST_N_I,
  output wire PERI_RST_N_O,
  output wire PERI_RST_N_OE,
  input wire IRQ_N_I,
  output wire IRQ_N_O,
  output wire IRQ_N_OE
);
  localparam [8:0] ST_INIT = 9'h001;
  localparam [8:0] ST_TBEGIN = 9'h002;
  localparam [8:0] ST_TEND = 9'h004;
  localparam [8:0] ST_RAMP = 9'h008;
  localparam [8:0] ST_ACTIVE = 9'h010;
  localparam [8:0] ST_ERROR = 9'h020;
  localparam [8:0] ST_LOCKED = 9'h040;
  localparam [8:0] ST_SLEEP = 9'h080;
  localparam [8:0] ST_SHUTDOWN = 9'h100;

  reg [8:0] state_ff, nxt_state;
  reg [31:0] ctrl_ff;
  reg [3:0] tally_ff, nxt_tally;
  reg por_flag_ff;
  reg wake_lat_ff;
  reg buck1_off_ff;
  reg [19:0] hold_ff, blank_ff;
  reg peri_low_ff;
  reg wd_trig_d_ff, wd_viol_d_ff, peri_pin_d_ff;
  reg [7:0] ramp_lvl_ff;
  reg [11:0] ramp_div_ff;
  reg aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff, rdata_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff, rresp_ff;

  wire wake_ok, batt_low, input_ov;
  wire por_cond = VIN_POR_LOW | LP_CLK_LOSS | DIE_OVERTEMP;
  wire fault_evt = (|BUCK_MON_FAULT) | LDO_OV | IO_SUPPLY_UV | GND_OPEN |
                   (|BUCK_OVERTEMP) | GATE_SUPPLY_OVERTEMP;
  wire wd_hit = WD_VIOLATION & ~wd_viol_d_ff &
                (state_ff == ST_ACTIVE);
  wire running = (state_ff == ST_TEND) | (state_ff == ST_RAMP) |
                 (state_ff == ST_ACTIVE);
  wire enter_err = running & fault_evt;
  wire count_evt = enter_err | wd_hit;
  wire [3:0] limit = ctrl_ff[`FSR_CTRL_LIM_HI:`FSR_CTRL_LIM_LO];
  wire pri_hold = (hold_ff != 20'h00000) | (state_ff != ST_ACTIVE);

  wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire wr_cmd = do_write & (awaddr_ff == `FSR_ADDR_CMD) & wstrb_ff[0];
  wire cmd_sleep = wr_cmd & wdata_ff[`FSR_CMD_SLEEP];
  wire cmd_lock = wr_cmd & wdata_ff[`FSR_CMD_LOCK];
  wire wr_ctrl = do_write & (awaddr_ff == `FSR_ADDR_CTRL);
  wire wr_stat = do_write & (awaddr_ff == `FSR_ADDR_STAT) & wstrb_ff[0];
  wire ar_take = S_AXI_ARVALID & ~rvalid_ff;

  fsr_filter #(
    .LEN(`FSR_WAKE_MIN_CYC)
  ) u_wake_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .din(WAKE),
    .dout(wake_ok)
  );

  fsr_filter #(
    .LEN(`FSR_BATT_FILT_CYC)
  ) u_batt_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .din(ctrl_ff[`FSR_CTRL_BATTSEL] ? BATT_BELOW_HIGH_THR :
         BATT_BELOW_LOW_THR),
    .dout(batt_low)
  );

  fsr_filter #(
    .LEN(`FSR_OV_FILT_CYC)
  ) u_ov_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .din(ctrl_ff[`FSR_CTRL_OVSEL] ? INPUT_OV_HIGH_THR :
         INPUT_OV_LOW_THR),
    .dout(input_ov)
  );

  // Operating state and restart tally
  always @* begin
    nxt_state = state_ff;
    nxt_tally = tally_ff;
    case (state_ff)
      ST_INIT: begin
        if (INIT_DONE) begin
          nxt_state = ST_TBEGIN;
        end
      end
      ST_TBEGIN: begin
        if (SELFTEST_BEGIN_OK) begin
          nxt_state = ST_TEND;
        end
      end
      ST_TEND: begin
        if (SELFTEST_END_OK) begin
          nxt_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (RAMP_DONE) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cmd_sleep) begin
          nxt_state = ST_SLEEP;
          if (tally_ff != 4'h0) begin
            nxt_tally = tally_ff - 4'h1;
          end
        end
      end
      ST_ERROR: begin
        if (!fault_evt) begin
          nxt_state = ST_TBEGIN;
        end
      end
      ST_LOCKED: begin
        nxt_state = ST_LOCKED;
      end
      ST_SLEEP: begin
        if (wake_lat_ff && WAKE) begin
          nxt_state = ST_TBEGIN;
        end
      end
      ST_SHUTDOWN: begin
        // Cooled die restarts as after power-on
        nxt_state = ST_INIT;
      end
      default: begin
        nxt_state = ST_INIT;
      end
    endcase
    if (enter_err) begin
      nxt_state = ST_ERROR;
    end
    if (count_evt) begin
      if (tally_ff + 4'h1 >= limit) begin
        nxt_state = ST_SLEEP;
        nxt_tally = 4'h0;
      end else begin
        nxt_tally = tally_ff + 4'h1;
      end
    end
    if (cmd_lock && state_ff != ST_SHUTDOWN) begin
      nxt_state = ST_LOCKED;
    end
  end

  // Internal power-on condition reinitialises the register set, with the state in ST_SHUTDOWN on die overtemperature
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_INIT;
      tally_ff <= 4'h0;
      ctrl_ff <= `FSR_CTRL_RESET;
      wake_lat_ff <= 1'b0;
      buck1_off_ff <= 1'b0;
    end else if (por_cond) begin
      state_ff <= DIE_OVERTEMP ? ST_SHUTDOWN : ST_INIT;
      tally_ff <= 4'h0;
      ctrl_ff <= `FSR_CTRL_RESET;
      wake_lat_ff <= 1'b0;
      buck1_off_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tally_ff <= nxt_tally;
      if (wr_ctrl) begin
        if (wstrb_ff[0]) begin
          ctrl_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          ctrl_ff[15:8] <= wdata_ff[15:8];
        end
      end
      if (state_ff != ST_SLEEP) begin
        wake_lat_ff <= 1'b0;
      end else if (wake_ok) begin
        wake_lat_ff <= 1'b1;
      end
      if (!input_ov) begin
        buck1_off_ff <= 1'b0;
      end else if (GATE_SUPPLY_UV || BUCK1_UV) begin
        buck1_off_ff <= 1'b1;
      end
    end
  end

  // Power-on flag: hardware set wins over software clear
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_flag_ff <= 1'b1;
    end else if (VIN_POR_LOW || DIE_OVERTEMP || CORE_SUPPLY_FAULT ||
                 LP_CLK_LOSS) begin
      por_flag_ff <= 1'b1;
    end else if (wr_stat && wdata_ff[`FSR_STAT_POR]) begin
      por_flag_ff <= 1'b0;
    end
  end

  // Reset outputs, interrupt blanking and soft-start ramp
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_ff <= 20'h00000;
      peri_low_ff <= 1'b1;
      wd_trig_d_ff <= 1'b0;
      wd_viol_d_ff <= 1'b0;
      peri_pin_d_ff <= 1'b0;
      blank_ff <= 20'h00000;
      ramp_lvl_ff <= 8'h00;
      ramp_div_ff <= 12'h000;
    end else begin
      wd_trig_d_ff <= WD_TRIGGER;
      wd_viol_d_ff <= WD_VIOLATION;
      peri_pin_d_ff <= PERI_RST_N_I;
      if (state_ff != ST_ACTIVE || wd_hit) begin
        hold_ff <= RESET_HOLD_CYC;
      end else if (hold_ff != 20'h00000) begin
        hold_ff <= hold_ff - 20'h00001;
      end
      if (hold_ff != 20'h00000 || state_ff != ST_ACTIVE) begin
        peri_low_ff <= 1'b1;
      end else if (WD_TRIGGER && !wd_trig_d_ff) begin
        peri_low_ff <= 1'b0;
      end
      if (!PERI_RST_N_I) begin
        blank_ff <= 20'h00000;
      end else if (!peri_pin_d_ff && batt_low) begin
        blank_ff <= BLANK_CYC;
      end else if (blank_ff != 20'h00000) begin
        blank_ff <= blank_ff - 20'h00001;
      end
      if (state_ff != ST_RAMP) begin
        ramp_lvl_ff <= 8'h00;
        ramp_div_ff <= 12'h000;
      end else if (ramp_div_ff == `FSR_RAMP_STEP_CYC - 1) begin
        ramp_div_ff <= 12'h000;
        if (ramp_lvl_ff != 8'hff) begin
          ramp_lvl_ff <= ramp_lvl_ff + 8'h01;
        end
      end else begin
        ramp_div_ff <= ramp_div_ff + 12'h001;
      end
    end
  end

  assign PRI_RST_N_O = 1'b0;
  assign PRI_RST_N_OE = pri_hold;
  assign PERI_RST_N_O = 1'b0;
  // Primary reset pulls the peripheral reset in the same cycle
  assign PERI_RST_N_OE = peri_low_ff | pri_hold;
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE = ~PERI_RST_N_I |
                    ((state_ff == ST_ACTIVE) & batt_low &
                     (blank_ff == 20'h00000));
  assign PASS_SWITCH_DRIVE = ~input_ov &
                             ((state_ff == ST_RAMP) |
                              (state_ff == ST_ACTIVE));
  assign BUCK1_RUN = ((state_ff == ST_RAMP) | (state_ff == ST_ACTIVE)) &
                     ~buck1_off_ff;
  assign BOOST_EN = ctrl_ff[`FSR_CTRL_BOOSTEN] & ~BOOST_OVERTEMP &
                    running;
  assign LDO_EN = ctrl_ff[`FSR_CTRL_LDOEN] & ~LDO_OVERTEMP & running;
  assign SOFTSTART_LEVEL = ramp_lvl_ff;
  assign LOWSIDE_DISCHARGE_EN = (state_ff == ST_RAMP);

  // AXI4-Lite slave: address and data taken in either order
  assign S_AXI_AWREADY = ~aw_full_ff & ~bvalid_ff;
  assign S_AXI_WREADY = ~w_full_ff & ~bvalid_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FSR_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (awaddr_ff == `FSR_ADDR_CTRL || awaddr_ff == `FSR_ADDR_CMD ||
            awaddr_ff == `FSR_ADDR_STAT) begin
          bresp_ff <= `FSR_RESP_OKAY;
        end else begin
          bresp_ff <= `FSR_RESP_SLVERR;
        end
      end else if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `FSR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `FSR_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      case (S_AXI_ARADDR)
        `FSR_ADDR_CTRL: begin
          rdata_ff <= ctrl_ff;
        end
        `FSR_ADDR_CMD: begin
          rdata_ff <= 32'h0000_0000;
        end
        `FSR_ADDR_STAT: begin
          rdata_ff[`FSR_STAT_POR] <= por_flag_ff;
          rdata_ff[`FSR_STAT_WAKE] <= wake_lat_ff;
          rdata_ff[`FSR_STAT_IRQ] <= IRQ_N_I;
          rdata_ff[`FSR_STAT_PRI] <= PRI_RST_N_I;
          rdata_ff[`FSR_STAT_PERI] <= PERI_RST_N_I;
          rdata_ff[`FSR_STAT_ST_HI:`FSR_STAT_ST_LO] <= state_ff;
          rdata_ff[`FSR_STAT_TAL_HI:`FSR_STAT_TAL_LO] <= tally_ff;
        end
        default: begin
          rresp_ff <= `FSR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- fsr_supervisor_checker.sv
// Concurrent checks on the fault and reset supervisor ports
`timescale 1ns/100ps
`default_nettype none
module fsr_supervisor_checker #(
  parameter [19:0] RESET_HOLD_CYC = 20'h14,
  parameter [19:0] BLANK_CYC = 20'ha
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic VIN_POR_LOW,
  input wire logic GND_OPEN,
  input wire logic BOOST_OVERTEMP,
  input wire logic WD_TRIGGER,
  input wire logic BATT_BELOW_LOW_THR,
  input wire logic BATT_BELOW_HIGH_THR,
  input wire logic INPUT_OV_LOW_THR,
  input wire logic INPUT_OV_HIGH_THR,
  input wire logic PASS_SWITCH_DRIVE,
  input wire logic BOOST_EN,
  input wire logic PERI_RST_N_I,
  input wire logic PRI_RST_N_OE,
  input wire logic PERI_RST_N_OE,
  input wire logic IRQ_N_OE
);
  logic [19:0] pri_cnt_ff;
  logic [9:0] ov_cnt_ff;
  logic [9:0] bat_cnt_ff;
  // Run lengths of held primary reset, overvoltage and low battery
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pri_cnt_ff <= '0;
      ov_cnt_ff <= '0;
      bat_cnt_ff <= '0;
    end else begin
      pri_cnt_ff <= PRI_RST_N_OE ? pri_cnt_ff + {19'h0, ~&pri_cnt_ff} : '0;
      ov_cnt_ff <= (INPUT_OV_LOW_THR && INPUT_OV_HIGH_THR) ?
                   ov_cnt_ff + {9'h0, ~&ov_cnt_ff} : '0;
      bat_cnt_ff <= (BATT_BELOW_LOW_THR && BATT_BELOW_HIGH_THR &&
                     PERI_RST_N_I) ? bat_cnt_ff + {9'h0, ~&bat_cnt_ff} : '0;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  chk_por_restart: assert property (
    VIN_POR_LOW |=> PRI_RST_N_OE && PERI_RST_N_OE && !PASS_SWITCH_DRIVE)
    else $error("outputs not in start state after power-on");
  chk_gnd_fault: assert property (
    GND_OPEN |=> PRI_RST_N_OE && PERI_RST_N_OE && !PASS_SWITCH_DRIVE)
    else $error("ground fault did not drop resets and switch");
  chk_ov_switch: assert property (
    ov_cnt_ff > 10'd420 |-> !PASS_SWITCH_DRIVE)
    else $error("pass switch on during input overvoltage");
  chk_boost_ot: assert property (BOOST_OVERTEMP |-> !BOOST_EN)
    else $error("boost enabled while overheated");
  chk_peri_follow: assert property (PRI_RST_N_OE |-> PERI_RST_N_OE)
    else $error("peripheral reset free while primary held");
  chk_peri_release: assert property (
    $fell(PERI_RST_N_OE) |-> !PRI_RST_N_OE &&
    (WD_TRIGGER || $past(WD_TRIGGER)))
    else $error("peripheral reset freed without trigger");
  chk_pri_hold: assert property (
    $fell(PRI_RST_N_OE) |-> pri_cnt_ff >= RESET_HOLD_CYC)
    else $error("primary reset released before hold time");
  chk_irq_peri: assert property (!PERI_RST_N_I |-> IRQ_N_OE)
    else $error("interrupt free while peripheral reset low");
  chk_irq_batt: assert property (bat_cnt_ff > 10'd900 |-> IRQ_N_OE)
    else $error("interrupt not raised on low battery");
endmodule
bind fsr_supervisor fsr_supervisor_checker #(
  .RESET_HOLD_CYC(RESET_HOLD_CYC),
  .BLANK_CYC(BLANK_CYC)
) u_chk (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .VIN_POR_LOW(VIN_POR_LOW),
  .GND_OPEN(GND_OPEN),
  .BOOST_OVERTEMP(BOOST_OVERTEMP),
  .WD_TRIGGER(WD_TRIGGER),
  .BATT_BELOW_LOW_THR(BATT_BELOW_LOW_THR),
  .BATT_BELOW_HIGH_THR(BATT_BELOW_HIGH_THR),
  .INPUT_OV_LOW_THR(INPUT_OV_LOW_THR),
  .INPUT_OV_HIGH_THR(INPUT_OV_HIGH_THR),
  .PASS_SWITCH_DRIVE(PASS_SWITCH_DRIVE),
  .BOOST_EN(BOOST_EN),
  .PERI_RST_N_I(PERI_RST_N_I),
  .PRI_RST_N_OE(PRI_RST_N_OE),
  .PERI_RST_N_OE(PERI_RST_N_OE),
  .IRQ_N_OE(IRQ_N_OE)
);
`default_nettype wire

//--- fsr_host_model.sv
// Host side: pin pull-ups and the first watchdog trigger
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
  input wire logic clk,
  input wire logic pri_oe,
  input wire logic peri_oe,
  input wire logic irq_oe,
  output logic pri_n,
  output logic peri_n,
  output logic irq_n,
  output logic wd_trig
);
  logic [3:0] dly_ff;
  assign pri_n = !pri_oe;
  assign peri_n = !peri_oe;
  assign irq_n = !irq_oe;
  // Trigger once, a few cycles after primary reset lets go
  always_ff @(posedge clk) begin
    if (!pri_n)
      dly_ff <= 4'h0;
    else if (dly_ff != 4'hf)
      dly_ff <= dly_ff + 4'h1;
  end
  assign wd_trig = (dly_ff >= 4'h6) && (dly_ff <= 4'h9);
endmodule
`default_nettype wire

//--- fault_reset_supervisor_bench.sv
// Self-checking bench for the fault and reset supervisor
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defines.vh"
module fault_reset_supervisor_bench;
  logic REF_CLK = 1'h0, RST_N = 1'h0, up = 1'h0, rdone = 1'h1;
  logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [31:0] S_AXI_WDATA = '0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  logic VIN_POR_LOW = 1'h0, LP_CLK_LOSS = 1'h0, DIE_OVERTEMP = 1'h0;
  logic CORE_SUPPLY_FAULT = 1'h0, BOOST_OVERTEMP = 1'h0, WAKE = 1'h0;
  logic LDO_OVERTEMP = 1'h0, GATE_SUPPLY_UV = 1'h0, BUCK1_UV = 1'h0;
  logic BATT_BELOW_LOW_THR = 1'h0, BATT_BELOW_HIGH_THR = 1'h0;
  logic INPUT_OV_LOW_THR = 1'h0, INPUT_OV_HIGH_THR = 1'h0;
  logic [6:0] flt = '0;
  wire [2:0] BUCK_MON_FAULT = {2'h0, flt[0]};
  wire [2:0] BUCK_OVERTEMP = {2'h0, flt[4]};
  wire LDO_OV = flt[1], IO_SUPPLY_UV = flt[2], GND_OPEN = flt[3];
  wire GATE_SUPPLY_OVERTEMP = flt[5], WD_VIOLATION = flt[6];
  wire INIT_DONE = up, SELFTEST_BEGIN_OK = up;
  wire SELFTEST_END_OK = up, RAMP_DONE = up & rdone;
  wire PASS_SWITCH_DRIVE, BUCK1_RUN, BOOST_EN, LDO_EN;
  wire LOWSIDE_DISCHARGE_EN, WD_TRIGGER;
  wire [7:0] SOFTSTART_LEVEL;
  wire PRI_RST_N_I, PRI_RST_N_O, PRI_RST_N_OE;
  wire PERI_RST_N_I, PERI_RST_N_O, PERI_RST_N_OE;
  wire IRQ_N_I, IRQ_N_O, IRQ_N_OE;
  int mismatches = 0, checks_done = 0, cyc = 0;
  logic [31:0] rv;
  logic [1:0] rr;
  fsr_supervisor #(.RESET_HOLD_CYC(20'h14), .BLANK_CYC(20'ha)) dut (.*);
  fsr_host_model host (.clk(REF_CLK), .pri_oe(PRI_RST_N_OE),
    .peri_oe(PERI_RST_N_OE), .irq_oe(IRQ_N_OE), .pri_n(PRI_RST_N_I),
    .peri_n(PERI_RST_N_I), .irq_n(IRQ_N_I), .wd_trig(WD_TRIGGER));
  always #12.5 REF_CLK = ~REF_CLK;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      $display("ERROR %0t run timed out", $time);
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    while (pa || pw) begin
      @(negedge REF_CLK);
      if (S_AXI_AWREADY) pa = 1'h0;
      if (S_AXI_WREADY) pw = 1'h0;
      @(posedge REF_CLK);
      S_AXI_AWVALID <= pa;
      S_AXI_WVALID <= pw;
    end
    do begin
      @(negedge REF_CLK);
      pa = S_AXI_BVALID;
      rr = S_AXI_BRESP;
      @(posedge REF_CLK);
    end while (!pa);
    S_AXI_BREADY <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic pa;
    pa = 1'h1;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    while (pa) begin
      @(negedge REF_CLK);
      if (S_AXI_ARREADY) pa = 1'h0;
      @(posedge REF_CLK);
      S_AXI_ARVALID <= pa;
    end
    do begin
      @(negedge REF_CLK);
      pa = S_AXI_RVALID;
      rv = S_AXI_RDATA;
      rr = S_AXI_RRESP;
      @(posedge REF_CLK);
    end while (!pa);
    S_AXI_RREADY <= 1'h0;
  endtask
  task automatic stat(input logic [8:0] st, input logic [3:0] tl);
    rd(`FSR_ADDR_STAT);
    chk({23'h0, rv[16:8]}, {23'h0, st});
    chk({28'h0, rv[23:20]}, {28'h0, tl});
  endtask
  task automatic wake_up;
    WAKE <= 1'h1;
    tick(2100);
    WAKE <= 1'h0;
    tick(60);
  endtask
  initial begin
    tick(12);
    RST_N <= 1'h1;
    rd(`FSR_ADDR_CTRL);
    chk(rv, `FSR_CTRL_RESET);
    stat(9'h001, 4'h0);
    chk(rv[0], 1'h1);
    rd(8'h0c);
    chk(rv, 32'h0);
    chk({30'h0, rr}, {30'h0, `FSR_RESP_SLVERR});
    wr(8'h0c, 32'h1);
    chk(rr, `FSR_RESP_SLVERR);
    rdone <= 1'h0;
    up <= 1'h1;
    tick(405);
    chk({LOWSIDE_DISCHARGE_EN, SOFTSTART_LEVEL}, 9'h101);
    rdone <= 1'h1;
    tick(60);
    stat(9'h010, 4'h0);
    chk({rv[4:3], PASS_SWITCH_DRIVE}, 3'h7);
    chk({LOWSIDE_DISCHARGE_EN, SOFTSTART_LEVEL}, 9'h000);
    INPUT_OV_LOW_THR <= 1'h1;
    tick(500);
    chk({PASS_SWITCH_DRIVE, BUCK1_RUN}, 2'h1);
    INPUT_OV_LOW_THR <= 1'h0;
    wr(`FSR_ADDR_CTRL, 32'h80f);
    rd(`FSR_ADDR_CTRL);
    chk(rv, 32'h80f);
    INPUT_OV_LOW_THR <= 1'h1;
    tick(500);
    chk(PASS_SWITCH_DRIVE, 1'h1);
    INPUT_OV_HIGH_THR <= 1'h1;
    tick(500);
    chk(PASS_SWITCH_DRIVE, 1'h0);
    BUCK1_UV <= 1'h1;
    tick(2);
    chk(BUCK1_RUN, 1'h0);
    BUCK1_UV <= 1'h0;
    INPUT_OV_LOW_THR <= 1'h0;
    INPUT_OV_HIGH_THR <= 1'h0;
    BOOST_OVERTEMP <= 1'h1;
    LDO_OVERTEMP <= 1'h1;
    tick(3);
    chk({BOOST_EN, LDO_EN}, 2'h0);
    stat(9'h010, 4'h0);
    BOOST_OVERTEMP <= 1'h0;
    LDO_OVERTEMP <= 1'h0;
    BATT_BELOW_HIGH_THR <= 1'h1;
    tick(100);
    BATT_BELOW_HIGH_THR <= 1'h0;
    tick(900);
    chk(IRQ_N_I, 1'h1);
    BATT_BELOW_HIGH_THR <= 1'h1;
    tick(1000);
    chk(IRQ_N_I, 1'h0);
    BATT_BELOW_LOW_THR <= 1'h1;
    tick(1000);
    BATT_BELOW_LOW_THR <= 1'h0;
    BATT_BELOW_HIGH_THR <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      flt <= 7'(1 << i);
      tick(4);
      stat(i == 6 ? 9'h010 : 9'h020, 4'(i + 1));
      flt <= '0;
      tick(60);
    end
    flt <= 7'h01;
    tick(4);
    stat(9'h080, 4'h0);
    chk(PASS_SWITCH_DRIVE, 1'h0);
    flt <= '0;
    WAKE <= 1'h1;
    tick(100);
    WAKE <= 1'h0;
    stat(9'h080, 4'h0);
    chk(rv[1], 1'h0);
    wake_up;
    stat(9'h010, 4'h0);
    wr(`FSR_ADDR_CMD, 32'h1);
    stat(9'h080, 4'h0);
    wake_up;
    flt <= 7'h08;
    tick(4);
    flt <= '0;
    tick(60);
    wr(`FSR_ADDR_CMD, 32'h1);
    stat(9'h080, 4'h0);
    wake_up;
    wr(`FSR_ADDR_CMD, 32'h2);
    stat(9'h040, 4'h0);
    wake_up;
    stat(9'h040, 4'h0);
    flt <= 7'h08;
    tick(4);
    flt <= '0;
    stat(9'h040, 4'h0);
    for (int s = 0; s < 3; s++) begin
      wr(`FSR_ADDR_CTRL, 32'h80f);
      wr(`FSR_ADDR_STAT, 32'h1);
      flt <= 7'h08;
      tick(4);
      flt <= '0;
      {DIE_OVERTEMP, LP_CLK_LOSS, VIN_POR_LOW} <= 3'(1 << s);
      tick(3);
      stat(s == 2 ? 9'h100 : 9'h001, 4'h0);
      chk(rv[0], 1'h1);
      rd(`FSR_ADDR_CTRL);
      chk(rv, `FSR_CTRL_RESET);
      {DIE_OVERTEMP, LP_CLK_LOSS, VIN_POR_LOW} <= 3'h0;
      tick(60);
      if (s == 2) begin
        stat(9'h010, 4'h0);
        VIN_POR_LOW <= 1'h1;
        tick(2);
        VIN_POR_LOW <= 1'h0;
        tick(60);
      end
    end
    wr(`FSR_ADDR_STAT, 32'h1);
    rd(`FSR_ADDR_STAT);
    chk(rv[0], 1'h0);
    CORE_SUPPLY_FAULT <= 1'h1;
    tick(3);
    CORE_SUPPLY_FAULT <= 1'h0;
    rd(`FSR_ADDR_STAT);
    chk(rv[0], 1'h1);
    end_of_test;
  end
endmodule
`default_nettype wire
